// ---- elm_pkg.sv ----
// Purpose: constants for the encoder link master control and status registers
// Assumes: 8-bit registers, each in one aligned 32-bit Avalon word
// Notes:   byte address is four times the register index
package elm_pkg;

  // ------------------------------------------------------------------
  // register indices and address width
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_SYSTEM_CONTROL = 8'h00;
  localparam logic [7:0] IDX_SYNC_CONTROL   = 8'h01;
  localparam logic [7:0] IDX_LINK_QUALITY   = 8'h03;
  localparam logic [7:0] IDX_HIGH_EVENTS    = 8'h04;
  localparam logic [7:0] IDX_LOW_EVENTS     = 8'h05;
  localparam logic [7:0] IDX_PIPE_STATUS    = 8'h2d;
  localparam logic [7:0] IDX_PIPE_DATA      = 8'h2e;
  localparam int         ADDR_W             = 10;

  // ------------------------------------------------------------------
  // system control fields
  // ------------------------------------------------------------------
  localparam int SC_PROTOCOL_RESET  = 7;
  localparam int SC_MSG_RESET       = 6;
  localparam int SC_FIFO_RESET      = 5;
  localparam int SC_READBACK        = 4;
  localparam int SC_STROBE_MODE     = 3;
  localparam int SC_PIPE_ENABLE     = 2;
  localparam int SC_SYNC_EDGE       = 1;
  localparam int SC_OUTPUT_ENABLE   = 0;

  // ------------------------------------------------------------------
  // event fields
  // ------------------------------------------------------------------
  localparam int EH_IRQ_STATE       = 7;
  localparam int EH_REMOTE_EVENT    = 6;
  localparam int EH_POSITION_ERROR  = 3;
  localparam int EH_DEVIATION_ERROR = 1;
  localparam int EH_PROTOCOL_RESET  = 0;
  localparam int EL_QUALITY_LOW     = 2;
  localparam logic [7:0] EH_CLEARABLE = 8'h4b;
  localparam logic [7:0] EL_CLEARABLE = 8'h04;

  // ------------------------------------------------------------------
  // reset values and quality figures
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h00;
  localparam logic [7:0] RST_SYNC_CONTROL   = 8'h01;
  localparam logic [7:0] RST_EVENTS         = 8'h00;
  localparam logic [3:0] QUALITY_INIT       = 4'h8;
  localparam logic [3:0] QUALITY_MAX        = 4'hf;
  localparam logic [3:0] QUALITY_WARN      = 4'he;
  localparam logic [4:0] PEN_SYNC_LAST      = 5'h04;
  localparam logic [4:0] PEN_SYNC_BODY      = 5'h06;
  localparam logic [4:0] PEN_WEAK_SIGNAL    = 5'h04;
  localparam logic [4:0] PEN_CODE_CHANNEL   = 5'h01;
  localparam logic [4:0] PEN_CODE_PROCESS   = 5'h02;
  localparam logic [4:0] PEN_UNKNOWN_CHAR   = 5'h02;
  localparam logic [4:0] PEN_SAFE1          = 5'h06;
  localparam logic [4:0] PEN_SAFE2          = 5'h08;
  localparam logic [1:0] SIGNAL_WEAK_LIMIT  = 2'h2;

  // ------------------------------------------------------------------
  // bus slave states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ELM_IDLE = 2'b01,
    ELM_DONE = 2'b10
  } elm_bus_t;

endpackage

// ---- elm_ctrl_status.sv ----
// Purpose: control and status register group of an encoder link master
// Assumes: Avalon-MM slave, one register per 32-bit word, synchronous inputs
// Notes:   protocol engine, pipeline FIFO and estimator sit outside
//
// Summary of operation
// [R1] only software writes change system control
// [R2] protocol reset bit holds protocol in reset
// [R3] message reset clears parameter channel messages
// [R4] fifo reset bit holds pipeline fifo reset
// [R5] readback bit is storage only
// [R6] strobe mode picks all or synced positions
// [R7] pipe enable zeroes fifo status, data registers
// [R8] sync edge select: one trailing, zero leading
// [R9] output enable drives cable, else high-z
// [R10] sampling count zero means free-running
// [R11] sync and signal errors lower quality score
// [R12] coding and safe channel errors lower score
// [R13] good sync and crc raise score
// [R14] score starts at eight, max fifteen
// [R15] score below fourteen raises low warning
// [R16] score zero reloads score, drops link for a cycle, sets protocol reset event
// [R17] quality register read-only, link and score
// [R18] hardware sets events, software clears them
// [R19] edge events set once, level events hold
// [R20] irq state bit mirrors interrupt output
// [R21] remote event flag follows masked slave events
// [R22] position and deviation errors set events
// [R23] three sources set protocol reset event
// [R24] low warning event at low bit two
// [R25] score saturates at zero and fifteen
`timescale 1ns/1ps
module elm_ctrl_status
  import elm_pkg::*;
#(
  parameter int DATA_W = 32
)
(
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic [elm_pkg::ADDR_W-1:0]    avs_address_in,
  input  wire logic                          avs_read_in,
  input  wire logic                          avs_write_in,
  input  wire logic [DATA_W-1:0]             avs_writedata_in,
  input  wire logic [3:0]                    avs_byteenable_in,
  output logic      [DATA_W-1:0]             avs_readdata_out,
  output logic                               avs_waitrequest_out,
  output logic                               avs_response_err_out,
  input  wire logic                          ext_reset_in,
  input  wire logic                          link_up_in,
  input  wire logic                          irq_level_in,
  input  wire logic                          remote_event_in,
  input  wire logic                          position_error_in,
  input  wire logic                          deviation_error_in,
  input  wire logic                          position_rx_in,
  input  wire logic                          position_synced_in,
  input  wire logic                          sync_pin_in,
  input  wire logic                          err_sync_last_in,
  input  wire logic                          err_sync_body_in,
  input  wire logic [1:0]                    signal_strength_indicator_in,
  input  wire logic                          signal_strength_valid_in,
  input  wire logic                          err_code_channel_in,
  input  wire logic                          err_code_process_in,
  input  wire logic                          err_unknown_char_in,
  input  wire logic                          err_safe1_in,
  input  wire logic                          err_safe2_in,
  input  wire logic                          good_sync_in,
  input  wire logic                          good_crc_in,
  input  wire logic [7:0]                    pipe_status_in,
  input  wire logic [7:0]                    pipe_data_in,
  output logic                               protocol_reset_out,
  output logic                               message_channel_reset_out,
  output logic                               pipeline_fifo_reset_out,
  output logic                               serial_pipe_enable_out,
  output logic                               position_valid_strobe_out,
  output logic                               sync_event_out,
  output logic [7:0]                         sync_sampling_count_out,
  output logic                               free_running_out,
  output logic                               cable_out,
  output logic                               cable_oe_n_out,
  input  wire logic                          cable_data_in,
  output logic                               link_out,
  output logic                               quality_low_warning_out
);

  // ------------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------------
  if (DATA_W < 8)
  begin : g_bad_width
    $error("DATA_W must be at least 8");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    elm_bus_t          bus;
    logic [DATA_W-1:0] rdata;
    logic              err;
    logic [7:0]        sysctl;
    logic [7:0]        syncctl;
    logic [3:0]        quality;
    logic              link;
    logic [7:0]        ev_high;
    logic [7:0]        ev_low;
    logic              pos_err_d;
    logic              dev_err_d;
    logic              ext_rst_d;
    logic              forced_rst;
    logic              sync_d;
    logic              sync_ev;
    logic              strobe;
    logic              cable;
    logic              msg_rst;
    logic              low_warn;
    logic              free_run;
    logic              oe_n;
  } elm_state_t;

  elm_state_t st_reg;
  elm_state_t st_next;

  function automatic logic [3:0] sat_add(input logic [3:0] q, input logic [4:0] up,
                                         input logic [4:0] dn);
    logic [5:0] sum;
    sum = {2'b00, q} + {1'b0, up};
    if (sum > {2'b00, QUALITY_MAX})
    begin
      sum = {2'b00, QUALITY_MAX};
    end
    if (sum < {1'b0, dn})
    begin
      sat_add = 4'h0;
    end
    else
    begin
      sat_add = 4'(sum - {1'b0, dn});
    end
  endfunction

  logic [7:0] idx;
  logic       hit;
  logic [7:0] rd8;
  logic [4:0] pen;
  logic [4:0] gain;
  logic [3:0] qnew;
  logic       wr_ok;
  logic       edge_hit;

  always_comb
  begin
    st_next  = st_reg;
    idx      = 8'(avs_address_in[ADDR_W-1:2]);
    hit      = 1'b1;
    rd8      = 8'h00;
    wr_ok    = avs_write_in && avs_byteenable_in[0];
    case (idx)
      IDX_SYSTEM_CONTROL: rd8 = st_reg.sysctl;
      IDX_SYNC_CONTROL:   rd8 = 8'h00;
      IDX_LINK_QUALITY:   rd8 = {st_reg.link, 3'b000, st_reg.quality}; // R17
      IDX_HIGH_EVENTS:    rd8 = st_reg.ev_high;
      IDX_LOW_EVENTS:     rd8 = st_reg.ev_low;
      IDX_PIPE_STATUS:    rd8 = st_reg.sysctl[SC_PIPE_ENABLE] ? 8'h00 : pipe_status_in; // R7
      IDX_PIPE_DATA:      rd8 = st_reg.sysctl[SC_PIPE_ENABLE] ? 8'h00 : pipe_data_in; // R7
      default:            hit = 1'b0;
    endcase

    // ------------------------------------------------------------------
    // bus slave: one wait cycle, answer on the second edge
    // ------------------------------------------------------------------
    st_next.msg_rst = 1'b0;
    case (st_reg.bus)
      ELM_IDLE:
      begin
        if (avs_read_in || avs_write_in)
        begin
          st_next.bus   = ELM_DONE;
          st_next.err   = !hit;
          st_next.rdata = avs_read_in ? {{(DATA_W-8){1'b0}}, rd8} : '0;
          if (wr_ok && idx == IDX_SYSTEM_CONTROL)
          begin
            st_next.sysctl  = avs_writedata_in[7:0]; // R1 R5
            st_next.msg_rst = avs_writedata_in[SC_MSG_RESET]; // R3
          end
          if (wr_ok && idx == IDX_SYNC_CONTROL)
          begin
            st_next.syncctl = avs_writedata_in[7:0]; // R10
          end
        end
      end
      ELM_DONE:
      begin
        st_next.bus = ELM_IDLE;
      end
      default:
      begin
        st_next.bus = ELM_IDLE;
      end
    endcase

    // ------------------------------------------------------------------
    // quality score
    // ------------------------------------------------------------------
    pen = 5'h00;
    if (err_sync_last_in) pen = pen + PEN_SYNC_LAST; // R11
    if (err_sync_body_in) pen = pen + PEN_SYNC_BODY; // R11
    if (signal_strength_valid_in && signal_strength_indicator_in < SIGNAL_WEAK_LIMIT)
      pen = pen + PEN_WEAK_SIGNAL; // R11
    if (err_code_channel_in) pen = pen + PEN_CODE_CHANNEL; // R12
    if (err_code_process_in) pen = pen + PEN_CODE_PROCESS; // R12
    if (err_unknown_char_in) pen = pen + PEN_UNKNOWN_CHAR; // R12
    if (err_safe1_in && pen < 5'h10) pen = pen + PEN_SAFE1; // R12
    if (err_safe2_in && pen < 5'h10) pen = pen + PEN_SAFE2; // R12
    gain = {4'h0, good_sync_in} + {4'h0, good_crc_in}; // R13
    qnew = sat_add(st_reg.quality, gain, pen); // R25
    st_next.forced_rst = 1'b0;
    if (st_reg.sysctl[SC_PROTOCOL_RESET] || st_reg.forced_rst)
    begin
      st_next.quality = QUALITY_INIT; // R2 R14
      st_next.link    = 1'b0;
    end
    else
    begin
      st_next.quality = qnew;
      st_next.link    = link_up_in; // R17
      if (qnew == 4'h0)
      begin
        st_next.forced_rst = 1'b1; // R16
      end
    end

    // ------------------------------------------------------------------
    // events: sets win over a clearing write in the same cycle
    // ------------------------------------------------------------------
    if (st_reg.bus == ELM_IDLE && wr_ok && idx == IDX_HIGH_EVENTS)
      st_next.ev_high = st_reg.ev_high & ~(avs_writedata_in[7:0] & EH_CLEARABLE); // R18
    if (st_reg.bus == ELM_IDLE && wr_ok && idx == IDX_LOW_EVENTS)
      st_next.ev_low = st_reg.ev_low & ~(avs_writedata_in[7:0] & EL_CLEARABLE); // R18
    st_next.pos_err_d = position_error_in;
    st_next.dev_err_d = deviation_error_in;
    st_next.ext_rst_d = ext_reset_in;
    if (position_error_in && !st_reg.pos_err_d)
      st_next.ev_high[EH_POSITION_ERROR] = 1'b1; // R19 R22
    if (deviation_error_in && !st_reg.dev_err_d)
      st_next.ev_high[EH_DEVIATION_ERROR] = 1'b1; // R19 R22
    if (remote_event_in)
      st_next.ev_high[EH_REMOTE_EVENT] = 1'b1; // R19 R21
    if ((avs_writedata_in[SC_PROTOCOL_RESET] && wr_ok && st_reg.bus == ELM_IDLE
         && idx == IDX_SYSTEM_CONTROL) || st_next.forced_rst
        || (ext_reset_in && !st_reg.ext_rst_d))
      st_next.ev_high[EH_PROTOCOL_RESET] = 1'b1; // R16 R23
    st_next.ev_high[EH_IRQ_STATE] = irq_level_in; // R20
    if (st_next.quality < QUALITY_WARN)
      st_next.ev_low[EL_QUALITY_LOW] = 1'b1; // R15 R24

    // ------------------------------------------------------------------
    // sync edge, position strobe and cable drive
    // ------------------------------------------------------------------
    st_next.sync_d = sync_pin_in;
    edge_hit = st_reg.sysctl[SC_SYNC_EDGE] ? (st_reg.sync_d && !sync_pin_in)
                                           : (!st_reg.sync_d && sync_pin_in); // R8
    st_next.sync_ev = edge_hit && (st_reg.syncctl != 8'h00); // R10
    st_next.strobe  = position_rx_in &&
                      (st_reg.sysctl[SC_STROBE_MODE] || position_synced_in); // R6
    st_next.cable   = cable_data_in;
    st_next.low_warn = st_next.quality < QUALITY_WARN;
    st_next.free_run = st_next.syncctl == 8'h00;
    st_next.oe_n = !st_next.sysctl[SC_OUTPUT_ENABLE];
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_reg            <= '0;
      st_reg.bus        <= ELM_IDLE;
      st_reg.sysctl     <= RST_SYSTEM_CONTROL;
      st_reg.syncctl    <= RST_SYNC_CONTROL;
      st_reg.quality    <= QUALITY_INIT; // R14
      st_reg.ev_high    <= RST_EVENTS;
      st_reg.ev_low     <= RST_EVENTS;
      st_reg.low_warn   <= 1'b1;
      st_reg.oe_n       <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all straight from state flops
  // ------------------------------------------------------------------
  assign avs_readdata_out          = st_reg.rdata;
  assign avs_waitrequest_out       = st_reg.bus[0];
  assign avs_response_err_out      = st_reg.err;
  assign protocol_reset_out        = st_reg.sysctl[SC_PROTOCOL_RESET]; // R2
  assign message_channel_reset_out = st_reg.msg_rst; // R3
  assign pipeline_fifo_reset_out   = st_reg.sysctl[SC_FIFO_RESET]; // R4
  assign serial_pipe_enable_out    = st_reg.sysctl[SC_PIPE_ENABLE]; // R7
  assign position_valid_strobe_out = st_reg.strobe; // R6
  assign sync_event_out            = st_reg.sync_ev;
  assign sync_sampling_count_out   = st_reg.syncctl;
  assign free_running_out          = st_reg.free_run; // R10
  assign cable_out                 = st_reg.cable;
  assign cable_oe_n_out            = st_reg.oe_n; // R9
  assign link_out                  = st_reg.link; // R17
  assign quality_low_warning_out   = st_reg.low_warn; // R15

endmodule // elm_ctrl_status

// ---- elm_checker.sv ----
// Purpose: port assertions for the link master control and status registers
// Assumes: bound to elm_ctrl_status, one clock domain
// Notes:   one wait cycle per access, control write visible in answer cycle
`timescale 1ns/1ps
module elm_checker
  import elm_pkg::*;
#(
  parameter int DATA_W = 32
)
(
  input wire logic                       clk_in,
  input wire logic                       rst_in,
  input wire logic [elm_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic                       avs_read_in,
  input wire logic                       avs_write_in,
  input wire logic [DATA_W-1:0]          avs_writedata_in,
  input wire logic [3:0]                 avs_byteenable_in,
  input wire logic [DATA_W-1:0]          avs_readdata_out,
  input wire logic                       avs_waitrequest_out,
  input wire logic                       avs_response_err_out,
  input wire logic                       protocol_reset_out,
  input wire logic                       message_channel_reset_out,
  input wire logic                       pipeline_fifo_reset_out,
  input wire logic                       serial_pipe_enable_out,
  input wire logic                       sync_event_out,
  input wire logic [7:0]                 sync_sampling_count_out,
  input wire logic                       free_running_out,
  input wire logic                       cable_oe_n_out
);
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  logic sc_wr;
  assign sc_wr = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
                 && avs_address_in[9:2] == IDX_SYSTEM_CONTROL;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("answer not one cycle after request");
  a_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer cycle longer than one");
  a_err_unmap: assert property (avs_read_in && !avs_waitrequest_out
    && avs_address_in[9:2] == 8'h02 |-> avs_response_err_out && avs_readdata_out == '0)
    else $error("unmapped read not refused");
  a_upper_zero: assert property (!avs_waitrequest_out |-> avs_readdata_out[DATA_W-1:8] == '0)
    else $error("upper read bits not zero");
  a_oe_write: assert property (sc_wr |-> cable_oe_n_out == !avs_writedata_in[0])
    else $error("cable enable does not follow control write");
  a_ctrl_write: assert property (sc_wr |-> {protocol_reset_out, pipeline_fifo_reset_out,
    serial_pipe_enable_out} == {avs_writedata_in[7], avs_writedata_in[5], avs_writedata_in[2]})
    else $error("control outputs do not follow write");
  a_ctrl_hold: assert property (!(avs_write_in && avs_address_in[9:3] == '0) |=>
    $stable({pipeline_fifo_reset_out, serial_pipe_enable_out, cable_oe_n_out,
    sync_sampling_count_out})) else $error("control changed without write");
  a_msg_pulse: assert property (message_channel_reset_out |->
    ($past(avs_write_in) || $past(avs_write_in, 2)) ##1 !message_channel_reset_out)
    else $error("message reset pulse wrong");
  a_free_run: assert property (free_running_out == (sync_sampling_count_out == 8'h00))
    else $error("free running flag wrong");
  c_ctrl_write: cover property (sc_wr);
  c_msg_reset: cover property (message_channel_reset_out);
  c_sync_event: cover property (sync_event_out);
endmodule // elm_checker

bind elm_ctrl_status elm_checker #(.DATA_W(DATA_W)) chk (.*);

// ---- elm_slave_model.sv ----
// Purpose: far-side encoder slave model: frame events and link setup
// Assumes: bench requests one-cycle event pulses
// Notes:   link comes up eight cycles after protocol reset drops
`timescale 1ns/1ps
module elm_slave_model
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       protocol_reset_in,
  input  wire logic [9:0] ev_req_in,
  output logic      [9:0] ev_out,
  output logic      [1:0] ssi_out,
  output logic            link_up_out
);
  // ------------------------------------------------------------------
  // frame events, strength readings with every frame, link setup
  // ------------------------------------------------------------------
  logic [2:0] up_reg;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ev_out <= '0;
      ssi_out <= 2'h3;
      up_reg <= '0;
      link_up_out <= 1'b0;
    end
    else
    begin
      ev_out <= {ev_req_in[9:3], |ev_req_in, ev_req_in[1:0]};
      ssi_out <= ev_req_in[2] ? 2'h1 : 2'h3;
      up_reg <= protocol_reset_in ? 3'h0 : (up_reg == 3'h7 ? up_reg : up_reg + 3'h1);
      link_up_out <= up_reg == 3'h7 && !protocol_reset_in;
    end
  end
endmodule // elm_slave_model

// ---- elm_ctrl_status_tb.sv ----
// Purpose: register tests of the link master control and status block
// Assumes: 20 MHz clock, Avalon-MM master with one wait cycle
// Notes:   event indices follow the slave model request vector
`timescale 1ns/1ps
module elm_ctrl_status_tb;
  import elm_pkg::*;
  logic clk_in = 0, rst_in = 1, avs_read_in = 0, avs_write_in = 0, ext_reset_in = 0, qe;
  logic irq_level_in = 0, remote_event_in = 0, sync_pin_in = 0, cable_data_in = 0;
  logic position_rx_in = 0, position_synced_in = 0, position_error_in = 0, deviation_error_in = 0;
  logic avs_waitrequest_out, avs_response_err_out, cable_out, link_up_in, link_out;
  logic protocol_reset_out, message_channel_reset_out, pipeline_fifo_reset_out, sync_event_out;
  logic serial_pipe_enable_out, position_valid_strobe_out, free_running_out, cable_oe_n_out;
  logic quality_low_warning_out, err_sync_last_in, err_sync_body_in, signal_strength_valid_in;
  logic err_code_channel_in, err_code_process_in, err_unknown_char_in, err_safe1_in;
  logic err_safe2_in, good_sync_in, good_crc_in;
  logic [1:0]  signal_strength_indicator_in;
  logic [3:0]  avs_byteenable_in = 4'hf;
  logic [7:0]  pipe_status_in = 8'h5a, pipe_data_in = 8'hc3, sync_sampling_count_out;
  logic [9:0]  avs_address_in = '0, req = '0, ev;
  logic [31:0] avs_writedata_in = '0, avs_readdata_out, q;
  int          miscompares = 0, total_checks = 0, n_str = 0, n_sev = 0, n_msg = 0;
  int          evs[18] = '{8, 8, 8, 8, 8, 8, 8, 9, 3, 3, 4, 5, 0, 8, 1, 7, 2, 6};
  logic [3:0]  qx[18] = '{4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'hf, 4'he, 4'hd,
                          4'hb, 4'h9, 4'h5, 4'h6, 4'h8, 4'h8, 4'h4, 4'h8};
  assign {good_crc_in, good_sync_in, err_safe2_in, err_safe1_in, err_unknown_char_in,
          err_code_process_in, err_code_channel_in, signal_strength_valid_in,
          err_sync_body_in, err_sync_last_in} = ev;
  elm_ctrl_status uut (.*);
  elm_slave_model far (.clk_in(clk_in), .rst_in(rst_in), .protocol_reset_in(protocol_reset_out),
    .ev_req_in(req), .ev_out(ev), .ssi_out(signal_strength_indicator_in),
    .link_up_out(link_up_in));
  initial forever #25 clk_in = ~clk_in;
  always @(posedge clk_in) cable_data_in <= ~cable_data_in;
  always @(posedge clk_in) n_str <= n_str + (position_valid_strobe_out === 1'b1);
  always @(posedge clk_in) n_sev <= n_sev + (sync_event_out === 1'b1);
  always @(posedge clk_in) n_msg <= n_msg + (message_channel_reset_out === 1'b1);
  // ------------------------------------------------------------------
  // bus access, compares, stimulus helpers
  // ------------------------------------------------------------------
  task automatic acc(input logic we, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, d};
    avs_write_in <= we;
    avs_read_in <= !we;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    qe = avs_response_err_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic chk1(string nm, logic e, logic g);
    chk8(nm, {7'h0, e}, {7'h0, g});
  endtask
  task automatic rc(string nm, logic [9:0] a, logic [7:0] e, logic [7:0] m);
    acc(1'b0, a, 8'h00);
    chk8(nm, e & m, q[7:0] & m);
  endtask
  task automatic pulse(int i);
    @(posedge clk_in);
    req <= 10'h001 << i;
    @(posedge clk_in);
    req <= '0;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic ppos(logic s);
    @(posedge clk_in);
    position_synced_in <= s;
    position_rx_in <= 1'b1;
    @(posedge clk_in);
    position_rx_in <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic sy(logic v, logic [7:0] e);
    @(posedge clk_in);
    sync_pin_in <= v;
    repeat (4) @(posedge clk_in);
    chk8("sync_events", e, 8'(n_sev));
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #1000000;
    miscompares++;
    finish_test();
  end
  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    rc("system_control", 10'h000, 8'h00, 8'hff);
    rc("sync_control", 10'h004, 8'h00, 8'hff);
    rc("link_quality", 10'h00c, 8'h08, 8'h7f);
    rc("high_events", 10'h010, 8'h00, 8'hff);
    rc("low_events", 10'h014, 8'h04, 8'hff);
    chk1("cable_oe_n", 1'b1, cable_oe_n_out);
    chk8("sampling_count", 8'h01, sync_sampling_count_out);
    acc(1'b1, 10'h00c, 8'hff);
    rc("quality_ro", 10'h00c, 8'h08, 8'h7f);
    acc(1'b0, 10'h008, 8'h00);
    chk1("unmapped_err", 1'b1, qe);
    $display("test reset and access done");
    for (int i = 0; i < 18; i++)
    begin
      pulse(evs[i]);
      rc("quality_score", 10'h00c, {4'h0, qx[i]}, 8'h7f);
      chk1("low_warning", qx[i] < 4'he, quality_low_warning_out);
      if (i == 7) acc(1'b1, 10'h014, 8'h04);
      if (i == 7 || i == 9) rc("low_events", 10'h014, {5'h0, i == 9, 2'h0}, 8'hff);
    end
    rc("forced_reset_event", 10'h010, 8'h01, 8'h01);
    acc(1'b1, 10'h010, 8'h4b);
    rc("event_cleared", 10'h010, 8'h00, 8'h01);
    acc(1'b1, 10'h000, 8'h80);
    chk1("protocol_reset", 1'b1, protocol_reset_out);
    repeat (10) @(posedge clk_in);
    rc("link_down", 10'h00c, 8'h00, 8'h80);
    rc("sw_reset_event", 10'h010, 8'h01, 8'h01);
    acc(1'b1, 10'h000, 8'h00);
    repeat (20) @(posedge clk_in);
    rc("link_up", 10'h00c, 8'h80, 8'h80);
    chk1("link_out", 1'b1, link_out);
    acc(1'b1, 10'h010, 8'h01);
    ext_reset_in <= 1'b1;
    rc("ext_reset_event", 10'h010, 8'h01, 8'h01);
    ext_reset_in <= 1'b0;
    $display("test quality and protocol reset done");
    acc(1'b1, 10'h000, 8'h1f);
    rc("control_readback", 10'h000, 8'h1f, 8'hff);
    chk1("cable_oe_n_on", 1'b0, cable_oe_n_out);
    rc("pipe_status_off", 10'h0b4, 8'h00, 8'hff);
    rc("pipe_data_off", 10'h0b8, 8'h00, 8'hff);
    acc(1'b1, 10'h000, 8'h40);
    rc("control_msg", 10'h000, 8'h40, 8'hff);
    chk8("msg_pulses", 8'h01, 8'(n_msg));
    rc("pipe_status_on", 10'h0b4, 8'h5a, 8'hff);
    acc(1'b1, 10'h000, 8'h20);
    chk1("fifo_reset", 1'b1, pipeline_fifo_reset_out);
    for (int k = 0; k < 2; k++)
    begin
      {position_error_in, deviation_error_in} <= k ? 2'b01 : 2'b10;
      rc("edge_event", 10'h010, 8'h08 >> (2 * k), 8'h0a);
      acc(1'b1, 10'h010, 8'h0a);
      rc("edge_held", 10'h010, 8'h00, 8'h0a);
    end
    {position_error_in, deviation_error_in} <= 2'b00;
    remote_event_in <= 1'b1;
    acc(1'b1, 10'h010, 8'h40);
    rc("remote_held", 10'h010, 8'h40, 8'h40);
    remote_event_in <= 1'b0;
    acc(1'b1, 10'h010, 8'h40);
    rc("remote_clear", 10'h010, 8'h00, 8'h40);
    irq_level_in <= 1'b1;
    acc(1'b1, 10'h010, 8'h80);
    rc("irq_state", 10'h010, 8'h80, 8'h80);
    $display("test control and events done");
    acc(1'b1, 10'h000, 8'h00);
    ppos(1'b0);
    chk8("strobe_unsynced", 8'h00, 8'(n_str));
    ppos(1'b1);
    acc(1'b1, 10'h000, 8'h08);
    ppos(1'b0);
    chk8("strobe_all", 8'h02, 8'(n_str));
    acc(1'b1, 10'h004, 8'h03);
    chk8("sampling_count", 8'h03, sync_sampling_count_out);
    sy(1'b1, 8'h01);
    sy(1'b0, 8'h01);
    acc(1'b1, 10'h000, 8'h02);
    sy(1'b1, 8'h01);
    sy(1'b0, 8'h02);
    acc(1'b1, 10'h004, 8'h00);
    sy(1'b1, 8'h02);
    sy(1'b0, 8'h02);
    $display("test strobe and sync done");
    finish_test();
  end
endmodule // elm_ctrl_status_tb
